// ==== hw/wvsa_div.v ====
// unsigned restoring divider, one quotient bit per clock
`timescale 1ns/1ns
module wvsa_div #(
    parameter NW = 48,
    parameter DW = 32
)(
    input wire clk,
    input wire sys_rst,
    input wire start,
    input wire [NW-1:0] num,
    input wire [DW-1:0] den,
    output reg done_r,
    output reg [NW-1:0] quo_r
);
reg [DW:0] rem_r;
reg [DW-1:0] den_r;
reg [NW-1:0] sh_r;
reg [7:0] cnt_r;
reg busy_r;
wire [DW:0] trial = {rem_r[DW-1:0], sh_r[NW-1]};
wire [DW:0] diff = trial - {1'b0, den_r};

// zero divisor yields all ones only when num fits in DW bits, no special case needed
always @(posedge clk) begin
    if (sys_rst) begin
        rem_r <= {(DW+1){1'b0}};
        den_r <= {DW{1'b0}};
        sh_r <= {NW{1'b0}};
        quo_r <= {NW{1'b0}};
        cnt_r <= 8'h00;
        busy_r <= 1'b0;
        done_r <= 1'b0;
    end else begin
        done_r <= 1'b0;
        if (start) begin
            rem_r <= {(DW+1){1'b0}};
            den_r <= den;
            sh_r <= num;
            cnt_r <= 8'h00;
            busy_r <= 1'b1;
        end else if (busy_r) begin
            sh_r <= {sh_r[NW-2:0], 1'b0};
            rem_r <= diff[DW] ? trial : diff;
            quo_r <= {quo_r[NW-2:0], ~diff[DW]};
            cnt_r <= cnt_r + 8'h01;
            if (cnt_r == NW - 1) begin
                busy_r <= 1'b0;
                done_r <= 1'b1;
            end
        end
    end
end
endmodule // wvsa_div

// ==== hw/wvsa_hist_mem.v ====
// small history memory with registered read data
`timescale 1ns/1ns
module wvsa_hist_mem #(
    parameter DW = 16,
    parameter AW = 4
)(
    input wire clk,
    input wire sys_rst,
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [DW-1:0] wdata,
    input wire [AW-1:0] raddr,
    output reg [DW-1:0] rdata_r
);
reg [DW-1:0] mem [0:(1<<AW)-1];

// array itself needs no reset, entries are counted in by the user
always @(posedge clk) begin
    if (we) begin
        mem[waddr] <= wdata;
    end
end

always @(posedge clk) begin
    if (sys_rst) begin
        rdata_r <= {DW{1'b0}};
    end else begin
        rdata_r <= mem[raddr];
    end
end
endmodule // wvsa_hist_mem

// ==== hw/wvsa_top.v ====
// wind and vapor pressure sampling, spike filter and interval report
`timescale 1ns/1ns
`include "wvsa_defines.vh"
// Behaviour
// - sample wind every 3 s, keep both components
// - report speed and direction from mean of accepted samples
// - gust is largest accepted speed since last query
// - running mean of speed over ten latest samples (code drops the previous sample, not the oldest entry being overwritten, once ten are held)
// - reject speed above eight times running mean
// - rejected samples skip gust and interval sums
// - no accepted sample gives an error report
// - forward then reverse pulse per axis, use phase difference
// - pulses use a 40 kHz carrier
// - receiver becomes next transmitter, four transducers in turn
// - velocity is c squared times phase difference over 2 f 27 mm
// - c squared from temperature, vapor pressure and air pressure
// - speed is magnitude of mean components, direction arctangent
// - 42 ms acquisition, then 60 ms before result use
// - host requests add extra wind samples
// - vapor pressure every 3 s, query reports interval mean
module wvsa_top #(
    parameter [31:0] TICK_CYC = `WVSA_TICK_CYC,
    parameter [31:0] ACQ_CYC = `WVSA_ACQ_CYC,
    parameter [31:0] CMP_CYC = `WVSA_CMP_CYC,
    parameter [3:0] HIST_N = `WVSA_HIST_N,
    parameter [4:0] BURST_PER = `WVSA_BURST_PER
)(
    input wire clk,
    input wire sys_rst,
    input wire [15:0] tmp_in,
    input wire [15:0] vp_in,
    input wire [19:0] ap_in,
    input wire signed [15:0] phase_in,
    input wire phase_valid,
    input wire meas_req,
    input wire query,
    output reg [1:0] tx_sel_r,
    output reg [1:0] rx_sel_r,
    output reg burst_r,
    output reg busy_r,
    output reg rpt_valid_r,
    output reg rpt_err_r,
    output reg [15:0] rpt_speed_r,
    output reg [15:0] rpt_dir_r,
    output reg [15:0] rpt_gust_r,
    output reg [15:0] rpt_vp_r
);
localparam S_IDLE = 4'd0;
localparam S_BURST = 4'd1;
localparam S_LISTEN = 4'd2;
localparam S_ACQ = 4'd3;
localparam S_CMP = 4'd4;
localparam S_RATIO = 4'd5;
localparam S_C2 = 4'd6;
localparam S_VEL = 4'd7;
localparam S_ROT = 4'd8;
localparam S_FILT = 4'd9;
localparam S_QDIV = 4'd10;
localparam S_REPORT = 4'd11;

reg [3:0] st_r;
reg [31:0] tick_cnt_r;
reg [31:0] tmr_r;
reg [9:0] car_r;
reg [4:0] half_r;
reg [1:0] leg_r;
reg axis_r;
reg [1:0] qidx_r;
reg is_query_r;
reg s_pend_r;
reg q_pend_r;
reg signed [15:0] ph_r [0:3];
reg [21:0] c2_r;
reg [15:0] ratio_r;
reg signed [15:0] vel_u_r;
reg signed [15:0] vel_v_r;
reg [15:0] spd_r;
reg signed [19:0] cx_r;
reg signed [19:0] cy_r;
reg [15:0] cz_r;
reg [3:0] ci_r;
reg [3:0] hist_cnt_r;
reg [3:0] hist_ptr_r;
reg [19:0] hist_sum_r;
reg signed [31:0] sum_u_r;
reg signed [31:0] sum_v_r;
reg [15:0] cnt_w_r;
reg [15:0] gust_r;
reg [31:0] sum_e_r;
reg [15:0] cnt_e_r;
reg signed [15:0] mean_u_r;
reg signed [15:0] mean_v_r;
reg div_start_r;
reg [47:0] div_num_r;
reg [31:0] div_den_r;
reg mem_we_r;
wire div_done;
wire [47:0] div_quo;
wire [15:0] hist_old;

// one shared divider serves ratio, velocity and interval means
wvsa_div #(.NW(48), .DW(32)) u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(div_start_r),
    .num(div_num_r),
    .den(div_den_r),
    .done_r(div_done),
    .quo_r(div_quo)
);

// ring of the latest speeds for the running mean
wvsa_hist_mem #(.DW(16), .AW(4)) u_hist (
    .clk(clk),
    .sys_rst(sys_rst),
    .we(mem_we_r),
    .waddr(hist_ptr_r),
    .wdata(spd_r),
    .raddr(hist_ptr_r),
    .rdata_r(hist_old)
);

wire tick = (tick_cnt_r == TICK_CYC - 32'd1);
wire s_take = (st_r == S_IDLE) && !q_pend_r && s_pend_r;
wire q_take = (st_r == S_IDLE) && q_pend_r;
wire acq_end = (tmr_r == ACQ_CYC - 32'd1);

// sound speed squared: T in 1/16 K times 20.067^2 in Q8
wire [32:0] c2_base = tmp_in * `WVSA_C2K;
wire [31:0] vp_frac = ratio_r * `WVSA_VPF;
wire [16:0] c2_fac = `WVSA_ONE_Q16 + {1'b0, vp_frac[31:16]};
wire [37:0] c2_full = c2_base[32:12] * c2_fac;

// phase difference between forward and reverse legs of one axis
wire signed [16:0] dn = axis_r ? (ph_r[1] - ph_r[3]) : (ph_r[0] - ph_r[2]);
wire [16:0] dn_abs = dn[16] ? -dn : dn;
wire [48:0] vel_num = c2_r * dn_abs * `WVSA_MM_PER_M;
wire [15:0] vel_sgn = dn[16] ? -div_quo[15:0] : div_quo[15:0];

// cordic vectoring step and final gain correction
wire signed [19:0] cx_sh = cx_r >>> ci_r;
wire signed [19:0] cy_sh = cy_r >>> ci_r;
wire [35:0] mag_full = cx_r[19:0] * `WVSA_CORDIC_GAIN;
reg [15:0] atan_v;
always @* begin
    case (ci_r)
        4'd0: atan_v = 16'h2000;
        4'd1: atan_v = 16'h12E4;
        4'd2: atan_v = 16'h09FB;
        4'd3: atan_v = 16'h0511;
        4'd4: atan_v = 16'h028B;
        4'd5: atan_v = 16'h0146;
        4'd6: atan_v = 16'h00A3;
        4'd7: atan_v = 16'h0051;
        4'd8: atan_v = 16'h0029;
        4'd9: atan_v = 16'h0014;
        4'd10: atan_v = 16'h000A;
        4'd11: atan_v = 16'h0005;
        default: atan_v = 16'h0000;
    endcase
end

// spike test without a divide: speed * count > 8 * sum
wire [19:0] old_spd = (hist_cnt_r == HIST_N) ? {4'h0, hist_old} : 20'h0_0000;
wire [23:0] spd_x_n = spd_r * hist_cnt_r;
wire [23:0] sum_x_8 = {1'b0, hist_sum_r, 3'b000};
wire spike = (hist_cnt_r != 4'd0) && (spd_x_n > sum_x_8);
wire [31:0] su_abs = sum_u_r[31] ? -sum_u_r : sum_u_r;
wire [31:0] sv_abs = sum_v_r[31] ? -sum_v_r : sum_v_r;

// 3 s pacing; pending flags let a new request win over its clear
always @(posedge clk) begin
    if (sys_rst) begin
        tick_cnt_r <= 32'h0000_0000;
        s_pend_r <= 1'b0;
        q_pend_r <= 1'b0;
    end else begin
        tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
        s_pend_r <= tick | meas_req | (s_pend_r & ~s_take);
        q_pend_r <= query | (q_pend_r & ~q_take);
    end
end

// vapor pressure sums run beside the wind path, cleared on report
always @(posedge clk) begin
    if (sys_rst) begin
        sum_e_r <= 32'h0000_0000;
        cnt_e_r <= 16'h0000;
    end else if (rpt_valid_r) begin
        sum_e_r <= tick ? {16'h0000, vp_in} : 32'h0000_0000;
        cnt_e_r <= tick ? 16'h0001 : 16'h0000;
    end else if (tick) begin
        sum_e_r <= sum_e_r + {16'h0000, vp_in};
        cnt_e_r <= cnt_e_r + 16'h0001;
    end
end

// main sequencer: acquire, compute, filter, accumulate, report
always @(posedge clk) begin
    if (sys_rst) begin
        st_r <= S_IDLE;
        tmr_r <= 32'h0000_0000;
        car_r <= 10'h000;
        half_r <= 5'h00;
        leg_r <= 2'h0;
        axis_r <= 1'b0;
        qidx_r <= 2'h0;
        is_query_r <= 1'b0;
        ph_r[0] <= 16'h0000;
        ph_r[1] <= 16'h0000;
        ph_r[2] <= 16'h0000;
        ph_r[3] <= 16'h0000;
        c2_r <= 22'h00_0000;
        ratio_r <= 16'h0000;
        vel_u_r <= 16'h0000;
        vel_v_r <= 16'h0000;
        spd_r <= 16'h0000;
        cx_r <= 20'h0_0000;
        cy_r <= 20'h0_0000;
        cz_r <= 16'h0000;
        ci_r <= 4'h0;
        hist_cnt_r <= 4'h0;
        hist_ptr_r <= 4'h0;
        hist_sum_r <= 20'h0_0000;
        sum_u_r <= 32'h0000_0000;
        sum_v_r <= 32'h0000_0000;
        cnt_w_r <= 16'h0000;
        gust_r <= 16'h0000;
        mean_u_r <= 16'h0000;
        mean_v_r <= 16'h0000;
        div_start_r <= 1'b0;
        div_num_r <= 48'h0000_0000_0000;
        div_den_r <= 32'h0000_0000;
        mem_we_r <= 1'b0;
        tx_sel_r <= 2'h0;
        rx_sel_r <= 2'h1;
        burst_r <= 1'b0;
        busy_r <= 1'b0;
        rpt_valid_r <= 1'b0;
        rpt_err_r <= 1'b0;
        rpt_speed_r <= 16'h0000;
        rpt_dir_r <= 16'h0000;
        rpt_gust_r <= 16'h0000;
        rpt_vp_r <= 16'h0000;
    end else begin
        div_start_r <= 1'b0;
        mem_we_r <= 1'b0;
        rpt_valid_r <= 1'b0;
        tmr_r <= tmr_r + 32'h0000_0001;
        case (st_r)
            S_IDLE: begin
                busy_r <= 1'b0;
                if (q_take) begin
                    busy_r <= 1'b1;
                    qidx_r <= 2'h0;
                    st_r <= S_QDIV;
                    div_start_r <= (cnt_w_r != 16'h0000);
                    div_num_r <= {16'h0000, su_abs};
                    div_den_r <= {16'h0000, cnt_w_r};
                end else if (s_take) begin
                    busy_r <= 1'b1;
                    tmr_r <= 32'h0000_0000;
                    leg_r <= 2'h0;
                    tx_sel_r <= 2'h0;
                    rx_sel_r <= 2'h1;
                    car_r <= 10'h000;
                    half_r <= 5'h00;
                    st_r <= S_BURST;
                end
            end
            // square wave at the carrier rate, BURST_PER periods long
            S_BURST: begin
                if (car_r == `WVSA_CAR_HALF - 1) begin
                    car_r <= 10'h000;
                    burst_r <= ~burst_r;
                    half_r <= half_r + 5'h01;
                    if (half_r == {BURST_PER[3:0], 1'b0} - 5'h01) begin
                        burst_r <= 1'b0;
                        st_r <= S_LISTEN;
                    end
                end else begin
                    car_r <= car_r + 10'h001;
                end
                if (acq_end) begin
                    burst_r <= 1'b0;
                    st_r <= S_IDLE;
                end
            end
            // legs 0 and 2 oppose on one axis, legs 1 and 3 on the other
            S_LISTEN: begin
                if (phase_valid) begin
                    ph_r[leg_r] <= phase_in;
                    tx_sel_r <= rx_sel_r;
                    rx_sel_r <= rx_sel_r + 2'h1;
                    leg_r <= leg_r + 2'h1;
                    car_r <= 10'h000;
                    half_r <= 5'h00;
                    st_r <= (leg_r == 2'h3) ? S_ACQ : S_BURST;
                end
                if (acq_end) begin
                    st_r <= S_IDLE; // missing echo: the sample is dropped
                end
            end
            S_ACQ: begin
                if (acq_end) begin
                    tmr_r <= 32'h0000_0000;
                    st_r <= S_CMP;
                end
            end
            S_CMP: begin
                if (tmr_r == CMP_CYC - 32'd1) begin
                    st_r <= S_RATIO;
                    div_start_r <= 1'b1;
                    div_num_r <= {16'h0000, vp_in, 16'h0000};
                    div_den_r <= {12'h000, ap_in};
                end
            end
            S_RATIO: begin
                if (div_done) begin
                    ratio_r <= div_quo[15:0];
                    st_r <= S_C2;
                end
            end
            S_C2: begin
                c2_r <= c2_full[37:16];
                axis_r <= 1'b0;
                st_r <= S_VEL;
                qidx_r <= 2'h0;
                div_den_r <= `WVSA_2FD;
            end
            // qidx marks a loaded axis, so a zero numerator cannot stall
            S_VEL: begin
                if (qidx_r == 2'h0) begin
                    div_num_r <= {8'h00, vel_num[47:8]};
                    div_start_r <= 1'b1;
                    qidx_r <= 2'h1;
                end else if (div_done) begin
                    qidx_r <= 2'h0;
                    if (!axis_r) begin
                        vel_u_r <= vel_sgn;
                        axis_r <= 1'b1;
                    end else begin
                        vel_v_r <= vel_sgn;
                        is_query_r <= 1'b0;
                        ci_r <= 4'h0;
                        cx_r <= vel_u_r[15] ? -{{4{vel_u_r[15]}}, vel_u_r} :
                            {{4{vel_u_r[15]}}, vel_u_r};
                        cy_r <= vel_u_r[15] ? -{{4{vel_sgn[15]}}, vel_sgn} :
                            {{4{vel_sgn[15]}}, vel_sgn};
                        cz_r <= vel_u_r[15] ? `WVSA_HALF_TURN : 16'h0000;
                        st_r <= S_ROT;
                    end
                end
            end
            // iterative rotation gives magnitude and angle together
            S_ROT: begin
                if (ci_r == `WVSA_CORDIC_N) begin
                    spd_r <= mag_full[31:16];
                    st_r <= is_query_r ? S_REPORT : S_FILT;
                end else begin
                    ci_r <= ci_r + 4'h1;
                    if (cy_r < 0) begin
                        cx_r <= cx_r - cy_sh;
                        cy_r <= cy_r + cx_sh;
                        cz_r <= cz_r - atan_v;
                    end else begin
                        cx_r <= cx_r + cy_sh;
                        cy_r <= cy_r - cx_sh;
                        cz_r <= cz_r + atan_v;
                    end
                end
            end
            // history always takes the sample; only accepted ones count
            S_FILT: begin
                mem_we_r <= 1'b1;
                hist_sum_r <= hist_sum_r - old_spd + {4'h0, spd_r};
                hist_ptr_r <= (hist_ptr_r == HIST_N - 4'd1) ? 4'h0 : hist_ptr_r + 4'h1;
                if (hist_cnt_r != HIST_N) begin
                    hist_cnt_r <= hist_cnt_r + 4'h1;
                end
                if (!spike) begin
                    sum_u_r <= sum_u_r + {{16{vel_u_r[15]}}, vel_u_r};
                    sum_v_r <= sum_v_r + {{16{vel_v_r[15]}}, vel_v_r};
                    cnt_w_r <= cnt_w_r + 16'h0001;
                    if (spd_r > gust_r) begin
                        gust_r <= spd_r;
                    end
                end
                st_r <= S_IDLE;
            end
            // interval means: east, north, then vapor pressure
            S_QDIV: begin
                if (div_done || (qidx_r != 2'h2 && cnt_w_r == 16'h0000) ||
                    (qidx_r == 2'h2 && cnt_e_r == 16'h0000)) begin
                    qidx_r <= qidx_r + 2'h1;
                    div_start_r <= 1'b1;
                    if (qidx_r == 2'h0) begin
                        mean_u_r <= sum_u_r[31] ? -div_quo[15:0] : div_quo[15:0];
                        div_num_r <= {16'h0000, sv_abs};
                        div_den_r <= {16'h0000, cnt_w_r};
                        div_start_r <= (cnt_w_r != 16'h0000);
                    end else if (qidx_r == 2'h1) begin
                        mean_v_r <= sum_v_r[31] ? -div_quo[15:0] : div_quo[15:0];
                        div_num_r <= {16'h0000, sum_e_r};
                        div_den_r <= {16'h0000, cnt_e_r};
                        div_start_r <= (cnt_e_r != 16'h0000);
                    end else begin
                        div_start_r <= 1'b0;
                        rpt_vp_r <= (cnt_e_r == 16'h0000) ? 16'h0000 : div_quo[15:0];
                        is_query_r <= 1'b1;
                        ci_r <= 4'h0;
                        cx_r <= mean_u_r[15] ? -{{4{mean_u_r[15]}}, mean_u_r} :
                            {{4{mean_u_r[15]}}, mean_u_r};
                        cy_r <= mean_u_r[15] ? -{{4{mean_v_r[15]}}, mean_v_r} :
                            {{4{mean_v_r[15]}}, mean_v_r};
                        cz_r <= mean_u_r[15] ? `WVSA_HALF_TURN : 16'h0000;
                        st_r <= S_ROT;
                    end
                end
            end
            // present the report, then start the next interval empty
            S_REPORT: begin
                rpt_valid_r <= 1'b1;
                rpt_err_r <= (cnt_w_r == 16'h0000);
                rpt_gust_r <= gust_r;
                rpt_speed_r <= (cnt_w_r == 16'h0000) ? 16'h0000 : spd_r;
                rpt_dir_r <= (cnt_w_r == 16'h0000) ? 16'h0000 : cz_r;
                sum_u_r <= 32'h0000_0000;
                sum_v_r <= 32'h0000_0000;
                cnt_w_r <= 16'h0000;
                gust_r <= 16'h0000;
                st_r <= S_IDLE;
            end
            default: begin
                st_r <= S_IDLE;
            end
        endcase
    end
end
endmodule // wvsa_top

// ==== inc/wvsa_defines.vh ====
// constants for the wind and vapor sample aggregator
`ifndef WVSA_DEFINES_VH
`define WVSA_DEFINES_VH

// clock and timing
`define WVSA_CLK_HZ 25000000
`define WVSA_TICK_MS 3000
`define WVSA_ACQ_MS 42
`define WVSA_CMP_MS 60
`define WVSA_TICK_CYC (`WVSA_TICK_MS * (`WVSA_CLK_HZ / 1000))
`define WVSA_ACQ_CYC (`WVSA_ACQ_MS * (`WVSA_CLK_HZ / 1000))
`define WVSA_CMP_CYC (`WVSA_CMP_MS * (`WVSA_CLK_HZ / 1000))

// ultrasonic carrier and path
`define WVSA_CARRIER_HZ 40000
`define WVSA_CAR_HALF (`WVSA_CLK_HZ / (2 * `WVSA_CARRIER_HZ))
`define WVSA_PATH_MM 27
`define WVSA_2FD (2 * `WVSA_CARRIER_HZ * `WVSA_PATH_MM / 1000)
`define WVSA_BURST_PER 8

// spike filter
`define WVSA_HIST_N 10
`define WVSA_SPIKE_SH 3

// sound speed model: 20.067^2 in Q8, 0.32 in Q16, unity in Q16
`define WVSA_C2K 17'h1_92AF
`define WVSA_VPF 16'h51EC
`define WVSA_ONE_Q16 17'h1_0000
`define WVSA_MM_PER_M 10'h3E8

// cordic: gain correction in Q16, half turn in angle units
`define WVSA_CORDIC_GAIN 16'h9B75
`define WVSA_HALF_TURN 16'h8000
`define WVSA_CORDIC_N 4'hC

`endif

// ==== verification/tb_wind_vapor_sample_aggregator.sv ====
// self-checking bench for the wind and vapor sample aggregator
`timescale 1ns/1ns
module tb_wind_vapor_sample_aggregator;
    localparam [31:0] TICK = 32'h0000_4E20;
    localparam [31:0] ACQ = 32'h0000_0FA0;
    localparam [31:0] CMP = 32'h0000_0064;
    reg clk, sys_rst, meas_req, query;
    reg [15:0] tmp_in, vp_in;
    reg [19:0] ap_in;
    reg signed [15:0] dn_e, dn_n;
    wire signed [15:0] phase_in;
    wire phase_valid, burst_r, busy_r, rpt_valid_r, rpt_err_r;
    wire [1:0] tx_sel_r, rx_sel_r;
    wire [15:0] rpt_speed_r, rpt_dir_r, rpt_gust_r, rpt_vp_r;
    wire [15:0] err_w = {15'h0000, rpt_err_r};
    int errors, samples_checked;
    wvsa_top #(.TICK_CYC(TICK), .ACQ_CYC(ACQ), .CMP_CYC(CMP), .BURST_PER(5'h01)) dut_u (
        .clk(clk), .sys_rst(sys_rst), .tmp_in(tmp_in), .vp_in(vp_in), .ap_in(ap_in),
        .phase_in(phase_in), .phase_valid(phase_valid), .meas_req(meas_req), .query(query),
        .tx_sel_r(tx_sel_r), .rx_sel_r(rx_sel_r), .burst_r(burst_r), .busy_r(busy_r),
        .rpt_valid_r(rpt_valid_r), .rpt_err_r(rpt_err_r), .rpt_speed_r(rpt_speed_r),
        .rpt_dir_r(rpt_dir_r), .rpt_gust_r(rpt_gust_r), .rpt_vp_r(rpt_vp_r));
    wvsa_echo_model echo_u (.clk(clk), .burst(burst_r), .tx_sel(tx_sel_r), .dn_e(dn_e),
        .dn_n(dn_n), .phase_valid(phase_valid), .phase_in(phase_in));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // expected axis speed, mm/s, phase in 1/256 wavelength
    function int vel(input real dn);
        real c2;
        c2 = 20.067 * 20.067 * (tmp_in / 16.0) * (1.0 + 0.32 * vp_in / ap_in);
        return int'(c2 * dn * 1000.0 / 256.0 / (2.0 * 40000.0 * 0.027));
    endfunction
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp,
        input int tol);
        samples_checked++;
        if (^seen === 1'bx || seen + tol < exp || seen > exp + tol) begin
            errors++;
            $display("mismatch %s expected %0d seen %0d", what, exp, seen);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // bounded wait: busy (sel 0) or report (sel 1)
    task wait_on(input int sel, input logic lvl, input int lim);
        int n;
        n = 0;
        while (((sel == 0) ? busy_r : rpt_valid_r) !== lvl) begin
            @(negedge clk);
            n++;
            if (n > lim) begin
                errors++;
                $display("mismatch wait %0d expected %0d seen timeout", sel, lvl);
                finish_test;
            end
        end
    endtask
    task take_sample(input int e, input int n);
        dn_e = e[15:0];
        dn_n = n[15:0];
        wait_on(0, 1'b0, 9000);
        meas_req = 1'b1;
        @(negedge clk);
        meas_req = 1'b0;
        wait_on(0, 1'b1, 9000);
        wait_on(0, 1'b0, 9000);
    endtask
    task do_query;
        query = 1'b1;
        @(negedge clk);
        query = 1'b0;
        wait_on(1, 1'b1, 9000);
    endtask
    // empty interval, twice in a row
    task test_idle;
        do_query;
        check("err", err_w, 16'h0001, 0);
        check("speed", rpt_speed_r, 16'h0000, 0);
        do_query;
        check("err", err_w, 16'h0001, 0);
        $display("test idle done");
    endtask
    // two requested samples of northward wind, before the first tick
    task test_north;
        take_sample(0, 2);
        take_sample(0, 2);
        do_query;
        check("err", err_w, 16'h0000, 0);
        check("speed", rpt_speed_r, vel(2.0), vel(2.0) / 50 + 2);
        check("dir", rpt_dir_r, 16'h4000, 64);
        check("gust", rpt_gust_r, vel(2.0), vel(2.0) / 50 + 2);
        check("vp", rpt_vp_r, 16'h0000, 0);
        do_query;
        check("err", err_w, 16'h0001, 0);
        $display("test north done");
    endtask
    // light wind with one spike
    task test_spike;
        do_query;
        repeat (9) take_sample(1, 0);
        take_sample(100, 0);
        take_sample(1, 0);
        do_query;
        check("err", err_w, 16'h0000, 0);
        check("gust", rpt_gust_r, vel(1.0), vel(1.0) / 50 + 4);
        check("speed", rpt_speed_r, vel(1.0), vel(1.0) / 50 + 4);
        $display("test spike done");
    endtask
    // tick alone fills the interval
    task test_tick;
        vp_in = 16'h07D0;
        do_query;
        repeat (TICK + 32'h0000_1388) @(negedge clk);
        do_query;
        check("err", err_w, 16'h0000, 0);
        check("vp", rpt_vp_r, 16'h07D0, 0);
        $display("test tick done");
    endtask
    initial begin
        sys_rst = 1'b1;
        tmp_in = 16'h1250;
        vp_in = 16'h03E8;
        ap_in = 20'h1_86A0;
        dn_e = 16'h0000;
        dn_n = 16'h0000;
        meas_req = 1'b0;
        query = 1'b0;
        errors = 0;
        samples_checked = 0;
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        test_idle;
        test_north;
        test_spike;
        test_tick;
        finish_test;
    end
endmodule // tb_wind_vapor_sample_aggregator

// ==== verification/wvsa_echo_model.sv ====
// echo responder standing in for the four transducer paths
`timescale 1ns/1ns
module wvsa_echo_model (
    input wire clk,
    input wire burst,
    input wire [1:0] tx_sel,
    input wire signed [15:0] dn_e,
    input wire signed [15:0] dn_n,
    output reg phase_valid,
    output reg signed [15:0] phase_in
);
    reg [9:0] quiet_r;
    reg armed_r;
    reg burst_d_r;
    initial begin
        phase_valid = 1'b0;
        phase_in = 16'h0000;
        quiet_r = 10'h000;
        armed_r = 1'b0;
        burst_d_r = 1'b0;
    end
    // echo once the carrier is quiet past a half period
    always @(posedge clk) begin
        burst_d_r <= burst;
        phase_valid <= 1'b0;
        phase_in <= ~phase_in; // no stale value between echoes
        if (burst != burst_d_r) begin
            armed_r <= 1'b1;
            quiet_r <= 10'h000;
        end else if (armed_r && quiet_r == 10'h140) begin
            armed_r <= 1'b0;
            phase_valid <= 1'b1;
            // forward leg gives the difference
            case (tx_sel)
                2'd0: phase_in <= dn_e;
                2'd1: phase_in <= dn_n;
                default: phase_in <= 16'h0000;
            endcase
        end else begin
            quiet_r <= quiet_r + 10'h001;
        end
    end
endmodule // wvsa_echo_model

// ==== verification/wvsa_top_properties.sv ====
// concurrent checks on the aggregator top ports
`timescale 1ns/1ns
`include "wvsa_defines.vh"
module wvsa_top_chk #(
    parameter [31:0] ACQ_CYC = `WVSA_ACQ_CYC,
    parameter [31:0] CMP_CYC = `WVSA_CMP_CYC
)(
    input wire clk,
    input wire sys_rst,
    input wire query,
    input wire [1:0] tx_sel_r,
    input wire [1:0] rx_sel_r,
    input wire burst_r,
    input wire busy_r,
    input wire rpt_valid_r,
    input wire rpt_err_r,
    input wire [15:0] rpt_speed_r,
    input wire [15:0] rpt_dir_r,
    input wire [15:0] rpt_gust_r
);
    localparam int HALF = `WVSA_CAR_HALF;
    // a query waits behind one sample at most
    localparam [31:0] LIM = ACQ_CYC + CMP_CYC + 32'h0000_07D0;
    reg [9:0] hi_cnt_r;
    reg [31:0] wait_r;
    reg pend_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // cycles of current carrier high half
    always @(posedge clk) begin
        if (sys_rst || !burst_r) hi_cnt_r <= 10'h000;
        else hi_cnt_r <= hi_cnt_r + 10'h001;
    end
    // age of the oldest unanswered query
    always @(posedge clk) begin
        if (sys_rst || rpt_valid_r) begin
            pend_r <= 1'b0;
            wait_r <= 32'h0000_0000;
        end else begin
            if (query) pend_r <= 1'b1;
            if (pend_r) wait_r <= wait_r + 32'h0000_0001;
        end
    end
    chk_valid_pulse: assert property (rpt_valid_r |=> !rpt_valid_r)
        else $error("strobe too long");
    chk_fields_hold: assert property (!rpt_valid_r && !$past(sys_rst) |-> $stable(rpt_speed_r)
        && $stable(rpt_dir_r) && $stable(rpt_gust_r) && $stable(rpt_err_r))
        else $error("fields moved");
    chk_query_bound: assert property (pend_r |-> wait_r < LIM)
        else $error("query late");
    chk_err_zero: assert property (rpt_valid_r && rpt_err_r |-> rpt_speed_r == 16'h0000
        && rpt_gust_r == 16'h0000 && rpt_dir_r == 16'h0000)
        else $error("error with values");
    chk_gust_cover: assert property (rpt_valid_r && !rpt_err_r
        |-> {1'b0, rpt_gust_r} + 17'h0_0004 >= {1'b0, rpt_speed_r})
        else $error("gust below mean speed");
    chk_burst_idle: assert property (!busy_r |-> !burst_r)
        else $error("carrier while idle");
    chk_burst_half: assert property ($fell(burst_r) && !$past(sys_rst) |-> hi_cnt_r == HALF)
        else $error("bad half period");
    chk_leg_order: assert property ($changed(tx_sel_r) && !$past(sys_rst)
        |-> tx_sel_r == $past(rx_sel_r))
        else $error("bad transmitter");
    chk_rx_next: assert property (rx_sel_r == tx_sel_r + 2'd1)
        else $error("bad receiver");
    cov_err_rpt: cover property (rpt_valid_r && rpt_err_r);
    cov_wind_rpt: cover property (rpt_valid_r && !rpt_err_r);
    cov_burst_end: cover property ($fell(burst_r));
endmodule // wvsa_top_chk

bind wvsa_top wvsa_top_chk #(.ACQ_CYC(ACQ_CYC), .CMP_CYC(CMP_CYC)) chk_u (
    .clk(clk), .sys_rst(sys_rst), .query(query), .tx_sel_r(tx_sel_r), .rx_sel_r(rx_sel_r),
    .burst_r(burst_r), .busy_r(busy_r), .rpt_valid_r(rpt_valid_r), .rpt_err_r(rpt_err_r),
    .rpt_speed_r(rpt_speed_r), .rpt_dir_r(rpt_dir_r), .rpt_gust_r(rpt_gust_r));
